// file: design/pfs_pkg.sv
// constants, field layouts and carrier types of the fault supervisor
// assumes a 10 MHz core clock from the internal oscillator
package pfs_pkg;

	localparam int CLK_NS  = 100;
	localparam int FILT_NS = 2000;
	localparam int SELF_NS = 100000;
	localparam int BK_NS   = 50000;
	localparam int RST_NS  = 1000000;

	localparam int CW = 16;
	localparam int FW = 8;

	localparam logic [FW-1:0] FILT_CYC = FW'((FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] SELF_CYC = CW'(SELF_NS / CLK_NS);
	localparam logic [CW-1:0] BK_CYC   = CW'(BK_NS / CLK_NS);
	localparam int            RST_CYC  = RST_NS / CLK_NS;

	localparam int AW = 4;
	localparam int DW = 32;

	localparam logic [AW-1:0] A_STAT = 4'h0;
	localparam logic [AW-1:0] A_CLR  = 4'h4;
	localparam logic [AW-1:0] A_MASK = 4'h8;
	localparam logic [AW-1:0] A_CTRL = 4'hc;

	localparam int NFLAG     = 24;
	localparam int F_BAT     = 0;
	localparam int F_BUCK_OV = 1;
	localparam int F_BUCK_UV = 2;
	localparam int F_BUCK_OC = 3;
	localparam int F_BST_OC  = 4;
	localparam int F_MAIN_OV = 5;
	localparam int F_MAIN_U1 = 6;
	localparam int F_MAIN_U2 = 7;
	localparam int F_CORE_AM = 8;
	localparam int F_CORE_OV = 9;
	localparam int F_CORE_UR = 10;
	localparam int F_CORE_UP = 11;
	localparam int F_T1_OV   = 12;
	localparam int F_T2_OV   = 13;
	localparam int F_T1_UV   = 14;
	localparam int F_T2_UV   = 15;
	localparam int F_T1_OC   = 16;
	localparam int F_T2_OC   = 17;
	localparam int F_TWARN   = 18;
	localparam int F_TSD     = 19;
	localparam int F_DETTST  = 20;
	localparam int F_OSC     = 21;
	localparam int F_TSDTST  = 22;
	localparam int F_BKUP    = 23;

	localparam logic [NFLAG-1:0] FAULT_BITS = 24'h7ffe7e;
	localparam logic [NFLAG-1:0] FLAG_RST   = 24'h000000;

	localparam int            MW       = 2;
	localparam int            M_T1OC   = 0;
	localparam int            M_T2OC   = 1;
	localparam logic [MW-1:0] MASK_RST = 2'h0;

	localparam int NCORE  = 4;
	localparam int C_AM   = 0;
	localparam int C_OV   = 1;
	localparam int C_UR   = 2;
	localparam int C_UP   = 3;

	typedef struct packed {
		logic battery_uv_detect;
		logic buck_ov_detect;
		logic buck_uv_detect;
		logic buck_oc_detect;
		logic boost_oc_detect;
		logic main_reg_ov_detect;
		logic main_reg_uv_first;
		logic main_reg_uv_second;
		logic core_absmax_detect;
		logic core_ov_detect;
		logic core_uv_reset_detect;
		logic core_uv_powerdown_detect;
		logic tracker_one_ov;
		logic tracker_two_ov;
		logic tracker_one_uv;
		logic tracker_two_uv;
		logic tracker_one_oc;
		logic tracker_two_oc;
		logic temp_warning;
		logic temp_shutdown;
	} pfs_det_s;

	typedef struct packed {
		logic lbist_done;
		logic lbist_err;
		logic det_test_fail;
		logic tsd_test_fail;
		logic osc_a_bad;
		logic osc_b_bad;
		logic rail_above_uv;
		logic rail_above_release;
	} pfs_tst_s;

	typedef struct packed {
		logic fault_irq_n;
		logic backup_power_enable;
		logic suspend_n;
		logic ext_ctrl_one;
		logic ext_ctrl_two;
		logic buck_stop;
		logic buck_interval;
		logic main_linear_reg_suspend;
		logic tracker_one_en;
		logic tracker_two_en;
		logic reset_n;
		logic powerdown;
		logic cmp_test;
		logic osc_sel;
		logic power_up;
	} pfs_out_s;

	localparam pfs_out_s OUT_RST = 15'h5800;

	typedef enum logic [2:0] {
		ST_LBIST,
		ST_HALT,
		ST_SELF,
		ST_BKUP,
		ST_RUN,
		ST_PDRST,
		ST_PD
	} pfs_state_e;

	typedef struct packed {
		pfs_det_s                 det_s1;
		pfs_det_s                 det_s2;
		pfs_tst_s                 tst_s1;
		pfs_tst_s                 tst_s2;
		logic [NCORE-1:0][FW-1:0] filt;
		logic [NFLAG-1:0]         flags;
		logic [MW-1:0]            mask;
		pfs_state_e               state;
		logic [CW-1:0]            cnt;
		logic                     osc_sel;
		logic                     bk_present;
		logic [DW-1:0]            rdata;
		pfs_out_s                 outs;
	} pfs_reg_s;

endpackage

// file: design/pfs_supervisor.sv
// fault supervisor: detector reactions, sticky flags, start-up self-diagnosis
// assumes detector and test inputs are asynchronous levels, bus on mclk_in
//
// Function
// - regulator over or under voltage detections drive fault output low, except main under second and core absolute-maximum
// - core detectors latch without release and ignore short glitches
// - battery under-voltage asserts the reset output
// - buck over-voltage stops switching, fault low, backup enable if present
// - buck under-voltage enters interval mode, fault low, backup enable if present
// - buck over-current enters interval mode, fault low, backup enable if present
// - boost over-current only drives fault low
// - main regulator over-voltage drives fault low, regulator keeps running
// - main under first: suspend, fault, ext one low, ext two high; second: reset, power-down
// - core absolute-maximum over-voltage suspends the main regulator
// - core over-voltage only drives fault low
// - first core under-voltage asserts reset and drives fault low
// - second core under-voltage suspends main regulator, fault low, power-down after reset
// - tracker over-voltage drives fault low, tracker keeps running
// - tracker under-voltage drives fault low and stops that tracker
// - tracker over-current drives fault low and stops that tracker
// - warning temperature drives fault low; shutdown temperature also powers down after reset
// - detectors self-tested on test voltage before power-up; failure drives fault low
// - internal logic self-test before reset release; error halts start-up
// - bad oscillator switches to healthy one, sets oscillator flag, fault low
// - thermal shutdown checked during self-diagnosis; failure drives fault low
// - backup enable pulsed once at start-up; rail above uv level means backup present
// - backup flag set if rail above release level while backup enable low
// - fault output returns high once software clears all pending flags
// - tracker over-current mask keeps that tracker on despite detection
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module pfs_supervisor #(
	parameter int RST_CYC = pfs_pkg::RST_CYC
) (
	input  wire logic                         mclk_in,
	input  wire logic                         reset_n_in,
	input  wire pfs_pkg::pfs_det_s            det_in,
	input  wire pfs_pkg::pfs_tst_s            tst_in,
	input  wire logic [pfs_pkg::AW-1:0]       addr_in,
	input  wire logic [pfs_pkg::DW-1:0]       wdata_in,
	input  wire logic                         wr_in,
	input  wire logic                         rd_in,
	output logic      [pfs_pkg::DW-1:0]       rdata_out,
	output pfs_pkg::pfs_out_s                 ctrl_out
);

	localparam logic [pfs_pkg::CW-1:0] RST_LAST = pfs_pkg::CW'(RST_CYC - 1);

	generate
		if (RST_CYC < 1 || RST_CYC > 65535) begin : g_bad_rst
			$error("RST_CYC out of counter range");
		end
	endgenerate

	pfs_pkg::pfs_reg_s r_ff;
	pfs_pkg::pfs_reg_s nxt_r;

	logic [pfs_pkg::NCORE-1:0] core_raw;
	logic [pfs_pkg::NCORE-1:0] core_hit;
	logic [pfs_pkg::NFLAG-1:0] set_v;
	logic [pfs_pkg::NFLAG-1:0] clr_v;
	logic                      armed;
	logic                      pd_req;
	logic                      cnt_end_self;
	logic                      cnt_end_bk;
	logic                      cnt_end_rst;
	logic                      bk_act;
	logic                      cur_bad;
	logic                      oth_bad;

	always_comb begin
		nxt_r = r_ff;

		// two-stage synchronisers
		nxt_r.det_s1 = det_in;
		nxt_r.det_s2 = r_ff.det_s1;
		nxt_r.tst_s1 = tst_in;
		nxt_r.tst_s2 = r_ff.tst_s1;

		armed = (r_ff.state == pfs_pkg::ST_RUN);

		// core glitch filters
		core_raw[pfs_pkg::C_AM] = r_ff.det_s2.core_absmax_detect;
		core_raw[pfs_pkg::C_OV] = r_ff.det_s2.core_ov_detect;
		core_raw[pfs_pkg::C_UR] = r_ff.det_s2.core_uv_reset_detect;
		core_raw[pfs_pkg::C_UP] = r_ff.det_s2.core_uv_powerdown_detect;
		for (int i = 0; i < pfs_pkg::NCORE; i++) begin
			core_hit[i] = core_raw[i] && (r_ff.filt[i] == pfs_pkg::FILT_CYC);
			if (!core_raw[i]) begin
				nxt_r.filt[i] = '0;
			end else if (r_ff.filt[i] != pfs_pkg::FILT_CYC) begin
				nxt_r.filt[i] = r_ff.filt[i] + 1'b1;
			end
		end

		// oscillator cross-monitor
		cur_bad = r_ff.osc_sel ? r_ff.tst_s2.osc_b_bad : r_ff.tst_s2.osc_a_bad;
		oth_bad = r_ff.osc_sel ? r_ff.tst_s2.osc_a_bad : r_ff.tst_s2.osc_b_bad;
		if (cur_bad && !oth_bad) begin
			nxt_r.osc_sel = !r_ff.osc_sel;
		end

		// detection events
		set_v = '0;
		set_v[pfs_pkg::F_BAT]     = armed && r_ff.det_s2.battery_uv_detect;
		set_v[pfs_pkg::F_BUCK_OV] = armed && r_ff.det_s2.buck_ov_detect;
		set_v[pfs_pkg::F_BUCK_UV] = armed && r_ff.det_s2.buck_uv_detect;
		set_v[pfs_pkg::F_BUCK_OC] = armed && r_ff.det_s2.buck_oc_detect;
		set_v[pfs_pkg::F_BST_OC]  = armed && r_ff.det_s2.boost_oc_detect;
		set_v[pfs_pkg::F_MAIN_OV] = armed && r_ff.det_s2.main_reg_ov_detect;
		set_v[pfs_pkg::F_MAIN_U1] = armed && r_ff.det_s2.main_reg_uv_first;
		set_v[pfs_pkg::F_MAIN_U2] = armed && r_ff.det_s2.main_reg_uv_second;
		set_v[pfs_pkg::F_CORE_AM] = armed && core_hit[pfs_pkg::C_AM];
		set_v[pfs_pkg::F_CORE_OV] = armed && core_hit[pfs_pkg::C_OV];
		set_v[pfs_pkg::F_CORE_UR] = armed && core_hit[pfs_pkg::C_UR];
		set_v[pfs_pkg::F_CORE_UP] = armed && core_hit[pfs_pkg::C_UP];
		set_v[pfs_pkg::F_T1_OV]   = armed && r_ff.det_s2.tracker_one_ov;
		set_v[pfs_pkg::F_T2_OV]   = armed && r_ff.det_s2.tracker_two_ov;
		set_v[pfs_pkg::F_T1_UV]   = armed && r_ff.det_s2.tracker_one_uv;
		set_v[pfs_pkg::F_T2_UV]   = armed && r_ff.det_s2.tracker_two_uv;
		set_v[pfs_pkg::F_T1_OC]   = armed && r_ff.det_s2.tracker_one_oc;
		set_v[pfs_pkg::F_T2_OC]   = armed && r_ff.det_s2.tracker_two_oc;
		set_v[pfs_pkg::F_TWARN]   = armed && r_ff.det_s2.temp_warning;
		set_v[pfs_pkg::F_TSD]     = armed && r_ff.det_s2.temp_shutdown;
		set_v[pfs_pkg::F_DETTST]  = (r_ff.state == pfs_pkg::ST_SELF)
			&& r_ff.tst_s2.det_test_fail;
		set_v[pfs_pkg::F_TSDTST]  = (r_ff.state == pfs_pkg::ST_SELF)
			&& r_ff.tst_s2.tsd_test_fail;
		set_v[pfs_pkg::F_OSC]     = cur_bad && !oth_bad;
		set_v[pfs_pkg::F_BKUP]    = (r_ff.state == pfs_pkg::ST_SELF)
			&& r_ff.tst_s2.rail_above_release;

		// software clear, set wins
		clr_v = '0;
		if (wr_in && addr_in == pfs_pkg::A_CLR) begin
			clr_v = wdata_in[pfs_pkg::NFLAG-1:0];
		end
		nxt_r.flags = (r_ff.flags & ~clr_v) | set_v;

		if (wr_in && addr_in == pfs_pkg::A_MASK) begin
			nxt_r.mask = wdata_in[pfs_pkg::MW-1:0];
		end

		// start-up and power-down sequencing
		pd_req = r_ff.flags[pfs_pkg::F_MAIN_U2] || r_ff.flags[pfs_pkg::F_CORE_UP]
			|| r_ff.flags[pfs_pkg::F_TSD];
		cnt_end_self = (r_ff.cnt == pfs_pkg::SELF_CYC - 1'b1);
		cnt_end_bk   = (r_ff.cnt == pfs_pkg::BK_CYC - 1'b1);
		cnt_end_rst  = (r_ff.cnt == RST_LAST);
		nxt_r.cnt    = r_ff.cnt + 1'b1;
		unique case (r_ff.state)
			pfs_pkg::ST_LBIST: begin
				nxt_r.cnt = '0;
				if (r_ff.tst_s2.lbist_done) begin
					nxt_r.state = r_ff.tst_s2.lbist_err ? pfs_pkg::ST_HALT
						: pfs_pkg::ST_SELF;
				end
			end
			pfs_pkg::ST_HALT: begin
				nxt_r.cnt = '0;
			end
			pfs_pkg::ST_SELF: begin
				if (cnt_end_self) begin
					nxt_r.state = pfs_pkg::ST_BKUP;
					nxt_r.cnt   = '0;
				end
			end
			pfs_pkg::ST_BKUP: begin
				if (cnt_end_bk) begin
					nxt_r.bk_present = r_ff.tst_s2.rail_above_uv;
					nxt_r.state      = pfs_pkg::ST_RUN;
					nxt_r.cnt        = '0;
				end
			end
			pfs_pkg::ST_RUN: begin
				nxt_r.cnt = '0;
				if (pd_req) begin
					nxt_r.state = pfs_pkg::ST_PDRST;
				end
			end
			pfs_pkg::ST_PDRST: begin
				if (cnt_end_rst) begin
					nxt_r.state = pfs_pkg::ST_PD;
					nxt_r.cnt   = '0;
				end
			end
			pfs_pkg::ST_PD: begin
				nxt_r.cnt = '0;
			end
		endcase

		// output decode
		bk_act = r_ff.bk_present && (r_ff.flags[pfs_pkg::F_BUCK_OV]
			|| r_ff.flags[pfs_pkg::F_BUCK_UV] || r_ff.flags[pfs_pkg::F_BUCK_OC]
			|| r_ff.flags[pfs_pkg::F_MAIN_U1]);
		nxt_r.outs.fault_irq_n = ~|(r_ff.flags & pfs_pkg::FAULT_BITS);
		nxt_r.outs.backup_power_enable = (r_ff.state == pfs_pkg::ST_BKUP)
			|| bk_act;
		nxt_r.outs.suspend_n    = !r_ff.flags[pfs_pkg::F_MAIN_U1];
		nxt_r.outs.ext_ctrl_one = !r_ff.flags[pfs_pkg::F_MAIN_U1];
		nxt_r.outs.ext_ctrl_two = r_ff.flags[pfs_pkg::F_MAIN_U1];
		nxt_r.outs.buck_stop    = r_ff.flags[pfs_pkg::F_BUCK_OV];
		nxt_r.outs.buck_interval = r_ff.flags[pfs_pkg::F_BUCK_UV]
			|| r_ff.flags[pfs_pkg::F_BUCK_OC];
		nxt_r.outs.main_linear_reg_suspend = r_ff.flags[pfs_pkg::F_CORE_AM]
			|| r_ff.flags[pfs_pkg::F_CORE_UP];
		nxt_r.outs.tracker_one_en = armed && !r_ff.flags[pfs_pkg::F_T1_UV]
			&& !(r_ff.flags[pfs_pkg::F_T1_OC]
			&& !r_ff.mask[pfs_pkg::M_T1OC]);
		nxt_r.outs.tracker_two_en = armed && !r_ff.flags[pfs_pkg::F_T2_UV]
			&& !(r_ff.flags[pfs_pkg::F_T2_OC]
			&& !r_ff.mask[pfs_pkg::M_T2OC]);
		nxt_r.outs.reset_n = armed && !r_ff.flags[pfs_pkg::F_BAT]
			&& !r_ff.flags[pfs_pkg::F_CORE_UR];
		nxt_r.outs.powerdown = (r_ff.state == pfs_pkg::ST_PD);
		nxt_r.outs.cmp_test  = (r_ff.state == pfs_pkg::ST_SELF);
		nxt_r.outs.osc_sel   = r_ff.osc_sel;
		nxt_r.outs.power_up  = armed;

		// register read, data one cycle later
		nxt_r.rdata = '0;
		if (rd_in) begin
			unique case (addr_in)
				pfs_pkg::A_STAT: nxt_r.rdata = pfs_pkg::DW'(r_ff.flags);
				pfs_pkg::A_MASK: nxt_r.rdata = pfs_pkg::DW'(r_ff.mask);
				pfs_pkg::A_CTRL: nxt_r.rdata = {13'h0000, r_ff.outs, r_ff.bk_present,
					r_ff.state};
				default:         nxt_r.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r_ff            <= '0;
			r_ff.flags      <= pfs_pkg::FLAG_RST;
			r_ff.mask       <= pfs_pkg::MASK_RST;
			r_ff.state      <= pfs_pkg::ST_LBIST;
			r_ff.outs       <= pfs_pkg::OUT_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign rdata_out = r_ff.rdata;
	assign ctrl_out  = r_ff.outs;

endmodule

// file: test/pfs_host_model.sv
// host side model: watches the fault line and counts its falling edges
// assumes the supervisor's control outputs and the same core clock
`timescale 1ns/1ps
module pfs_host_model (
	input  wire logic              mclk_in,
	input  wire logic              reset_n_in,
	input  wire pfs_pkg::pfs_out_s ctrl_in,
	output logic [7:0]             fault_cnt_out
);
	logic       irq_ff;
	logic [7:0] cnt_ff;
	assign fault_cnt_out = cnt_ff;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_ff <= 1'b1;
			cnt_ff <= 8'h0;
		end else begin
			irq_ff <= ctrl_in.fault_irq_n;
			if (irq_ff && !ctrl_in.fault_irq_n) begin
				cnt_ff <= cnt_ff + 8'h1;
			end
		end
	end
endmodule

// file: test/pfs_sva.sv
// port checker of the fault supervisor
// assumes one clock domain, bound onto pfs_supervisor
`timescale 1ns/1ps
module pfs_sva (
	input wire logic                   mclk_in,
	input wire logic                   reset_n_in,
	input wire pfs_pkg::pfs_det_s      det_in,
	input wire pfs_pkg::pfs_tst_s      tst_in,
	input wire logic [pfs_pkg::AW-1:0] addr_in,
	input wire logic [pfs_pkg::DW-1:0] wdata_in,
	input wire logic                   wr_in,
	input wire logic                   rd_in,
	input wire logic [pfs_pkg::DW-1:0] rdata_out,
	input wire pfs_pkg::pfs_out_s      ctrl_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	logic        run;
	logic        clr;
	logic        st_ff;
	logic [15:0] bk_ff;
	assign run = ctrl_out.power_up;
	assign clr = wr_in && (addr_in == pfs_pkg::A_CLR);
	// length of the start-up backup pulse
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= 1'b0;
			bk_ff <= 16'h0;
		end else begin
			st_ff <= st_ff | ctrl_out.cmp_test;
			bk_ff <= (ctrl_out.backup_power_enable && !run && st_ff) ? bk_ff + 16'h1 : 16'h0;
		end
	end
	AST_MAIN_OV: assert property (
		(run && det_in.main_reg_ov_detect) [*3] |-> ##[0:4] !ctrl_out.fault_irq_n)
		else $error("main ov gave no fault");
	AST_BAT_RST: assert property (
		(run && det_in.battery_uv_detect) [*3] |-> ##[0:4] !ctrl_out.reset_n)
		else $error("battery uv gave no reset");
	AST_MAIN_UV1: assert property (
		(run && det_in.main_reg_uv_first) [*3] |-> ##[0:4] (!ctrl_out.suspend_n
		&& !ctrl_out.fault_irq_n && !ctrl_out.ext_ctrl_one && ctrl_out.ext_ctrl_two))
		else $error("main uv first reaction wrong");
	AST_TRK_UV: assert property (
		(run && det_in.tracker_one_uv) [*3] |-> ##[0:4]
		(!ctrl_out.tracker_one_en && !ctrl_out.fault_irq_n))
		else $error("tracker one uv not stopped");
	AST_FAULT_REL: assert property (
		run && $rose(ctrl_out.fault_irq_n) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
		else $error("fault released without clear");
	AST_OSC: assert property (
		$rose(ctrl_out.osc_sel) |-> ##[0:2] !ctrl_out.fault_irq_n)
		else $error("osc switch without fault");
	AST_BK_LEN: assert property (
		$fell(ctrl_out.backup_power_enable) && st_ff && !$past(run) |-> bk_ff == pfs_pkg::BK_CYC)
		else $error("backup pulse length wrong");
	AST_BK_FIRST: assert property (
		$rose(ctrl_out.backup_power_enable) && !run |-> $past(ctrl_out.cmp_test))
		else $error("backup pulse not after selftest");
	AST_PU_ORDER: assert property (
		$rose(run) |-> $past(ctrl_out.backup_power_enable))
		else $error("power up not after backup pulse");
	AST_LBIST: assert property (
		$rose(ctrl_out.cmp_test) |-> $past(tst_in.lbist_done) && !$past(tst_in.lbist_err))
		else $error("selftest began without clean lbist");
endmodule
bind pfs_supervisor pfs_sva chk_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.det_in(det_in), .tst_in(tst_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ctrl_out(ctrl_out));

// file: test/tb.sv
// self-checking bench of the fault supervisor
// assumes short power-down reset count, bus tasks on mclk_in
`timescale 1ns/1ps
module tb;
	logic                   mclk_in    = 1'b0;
	logic                   reset_n_in = 1'b0;
	pfs_pkg::pfs_det_s      det_in     = '0;
	pfs_pkg::pfs_tst_s      tst_in     = '0;
	logic [pfs_pkg::AW-1:0] addr_in    = '0;
	logic [pfs_pkg::DW-1:0] wdata_in   = '0;
	logic                   wr_in      = 1'b0;
	logic                   rd_in      = 1'b0;
	logic [pfs_pkg::DW-1:0] rdata_out;
	pfs_pkg::pfs_out_s      ctrl_out;
	logic [7:0]             fcnt;
	logic [31:0]            d;
	int                     err_total  = 0;
	int                     num_checks = 0;
	pfs_supervisor #(.RST_CYC(8)) dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.det_in(det_in), .tst_in(tst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ctrl_out(ctrl_out));
	pfs_host_model host_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ctrl_in(ctrl_out),
		.fault_cnt_out(fcnt));
	initial begin
		forever #50 mclk_in = ~mclk_in;
	end
	task chk1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %b got %b", n, e, g);
		end
	endtask
	task chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task report_and_stop;
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge mclk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task wait_bit(input int b, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge mclk_in);
			if (ctrl_out[b] === 1'b1) return;
		end
		err_total++;
		$display("[FAIL] wait on ctrl bit %0d", b);
		report_and_stop;
	endtask
	task boot(input logic [7:0] t);
		@(posedge mclk_in);
		reset_n_in <= 1'b0;
		tst_in <= t;
		det_in <= '0;
		repeat (10) @(posedge mclk_in);
		reset_n_in <= 1'b1;
	endtask
	task clear_all;
		wr(pfs_pkg::A_CLR, 32'hffffff);
		repeat (4) @(posedge mclk_in);
		chk1("fault_rel", 1'b1, ctrl_out.fault_irq_n);
	endtask
	initial begin
		boot(8'h82);
		chk32("rst_ctrl", 32'h5800, {17'h0, ctrl_out});
		wait_bit(0, 3000);
		rd(pfs_pkg::A_CTRL, d);
		chk32("ctrl_reg", 32'hc, {28'h0, d[3:0]});
		wr(pfs_pkg::A_MASK, 32'h2);
		rd(pfs_pkg::A_MASK, d);
		chk32("mask", 32'h2, d);
		rd(4'h1, d);
		chk32("unmapped", 32'h0, d);
		@(posedge mclk_in);
		det_in.core_ov_detect <= 1'b1;
		repeat (10) @(posedge mclk_in);
		det_in <= '0;
		repeat (30) @(posedge mclk_in);
		rd(pfs_pkg::A_STAT, d);
		chk32("glitch", 32'h0, d);
		for (int i = 0; i < 19; i++) begin
			if (i == 7 || i == 11) continue;
			@(posedge mclk_in);
			det_in <= 20'h80000 >> i;
			repeat (30) @(posedge mclk_in);
			det_in <= '0;
			repeat (4) @(posedge mclk_in);
			rd(pfs_pkg::A_STAT, d);
			chk32("flag", 32'h1 << i, d);
			chk1("fault", !pfs_pkg::FAULT_BITS[i], ctrl_out.fault_irq_n);
			case (i)
				0, 10: chk1("reset", 1'b0, ctrl_out.reset_n);
				1: chk1("buck_stop", 1'b1, ctrl_out.buck_stop);
				2, 3: begin
					chk1("bk_en", 1'b1, ctrl_out.backup_power_enable);
					chk1("buck_int", 1'b1, ctrl_out.buck_interval);
				end
				4: chk1("boost_bk", 1'b0, ctrl_out.backup_power_enable);
				5, 9: chk1("main_suspend_out", 1'b0, ctrl_out.main_linear_reg_suspend);
				6: chk1("ext_two", 1'b1, ctrl_out.ext_ctrl_two);
				8: chk1("main_suspend_out", 1'b1, ctrl_out.main_linear_reg_suspend);
				12, 16: chk1("trk1", i == 12, ctrl_out.tracker_one_en);
				17: chk1("trk2", 1'b1, ctrl_out.tracker_two_en);
				default: ;
			endcase
			clear_all;
		end
		@(posedge mclk_in);
		tst_in <= 8'h8a;
		repeat (8) @(posedge mclk_in);
		chk1("osc_sel", 1'b1, ctrl_out.osc_sel);
		tst_in <= 8'h82;
		rd(pfs_pkg::A_STAT, d);
		chk32("osc_flag", 32'h200000, d);
		clear_all;
		det_in.temp_shutdown <= 1'b1;
		repeat (8) @(posedge mclk_in);
		chk1("tsd_fault", 1'b0, ctrl_out.fault_irq_n);
		wait_bit(3, 40);
		chk1("pd_reset", 1'b0, ctrl_out.reset_n);
		boot(8'hb1);
		wait_bit(0, 3000);
		rd(pfs_pkg::A_STAT, d);
		chk32("selftest", 32'hd00000, d);
		chk1("st_fault", 1'b0, ctrl_out.fault_irq_n);
		chk32("host_seen", 32'h1, {24'h0, fcnt});
		rd(pfs_pkg::A_CTRL, d);
		chk32("no_backup", 32'h4, {28'h0, d[3:0]});
		@(posedge mclk_in);
		det_in.main_reg_uv_second <= 1'b1;
		wait_bit(3, 40);
		chk1("uv2_reset", 1'b0, ctrl_out.reset_n);
		boot(8'h82);
		wait_bit(0, 3000);
		@(posedge mclk_in);
		det_in.core_uv_powerdown_detect <= 1'b1;
		repeat (30) @(posedge mclk_in);
		chk1("core_pd_suspend_out", 1'b1, ctrl_out.main_linear_reg_suspend);
		chk1("core_pd_fault", 1'b0, ctrl_out.fault_irq_n);
		wait_bit(3, 40);
		chk1("core_pd_reset", 1'b0, ctrl_out.reset_n);
		boot(8'hc0);
		repeat (100) @(posedge mclk_in);
		chk1("halt_pu", 1'b0, ctrl_out.power_up);
		rd(pfs_pkg::A_CTRL, d);
		chk32("halt", 32'h1, {29'h0, d[2:0]});
		report_and_stop;
	end
endmodule
